// file: i2c_single_bit_control_tb.sv
// Purpose: self-checking bench for the single-bit two-wire bus port
// Assumes: zero-wait APB slave, open-drain wires with pull-ups
// Notes:   restart generation is not exercised
`timescale 1ns/1ns
`default_nettype none
module i2c_single_bit_control_tb;
  import i2cbit_pkg::*;
  localparam logic [11:0] CR = CTRL_ADDR;
  localparam logic [11:0] DR = DATA_ADDR;
  logic         core_clk, nrst, psel, penable, pwrite, pready, pslverr, lastErr;
  logic [31:0]  paddr, pwdata, prdata, rd;
  i2cbit_pins_t pinsIn;
  i2cbit_drv_t  drvOut;
  logic         sclLow, sdaLow, hung;
  wire          sclLine, sdaLine;
  int           mismatches = 0;
  int           checked = 0;
  // ==========================================================
  // wired-and of both parties, pull-up when nobody drives
  assign sclLine = ~(drvOut.sclOe | sclLow);
  assign sdaLine = ~(drvOut.sdaOe | sdaLow);
  assign pinsIn = '{sclIn: sclLine, sdaIn: sdaLine};
  i2cbit_core dut_u (.core_clk(core_clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .pinsIn(pinsIn), .drvOut(drvOut));
  i2cbit_bus_model busModel (.sclLine(sclLine), .sdaLine(sdaLine), .sclLow(sclLow),
    .sdaLow(sdaLow), .hung(hung));
  // clock
  initial begin
    core_clk = 1'h0;
    forever #25 core_clk = ~core_clk;
  end
  // ==========================================================
  // shared tasks
  task automatic complete_run();
    if (mismatches == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // one APB transfer; read data lands in rd, error flag in lastErr
  task automatic apb(input logic wr, input logic [11:0] a, input logic [7:0] wd);
    int n;
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= {20'h0, a};
    pwdata  <= {24'h0, wd};
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    rd = prdata;
    lastErr = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    if (n >= 20) begin
      mismatches++;
      complete_run();
    end
    @(posedge core_clk);
  endtask
  // ==========================================================
  // scenarios
  task automatic testResetMap();
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'hfe, 32'h80);
    chk({30'h0, drvOut}, 32'h0);
    apb(1'h0, 12'h0e0, 8'h0);
    chk({31'h0, lastErr}, 32'h1);
    chk(rd, 32'h0);
  endtask
  // start seen, then stretching survives clearing ready alone or writing zeros
  task automatic testStart();
    busModel.sendStart();
    cyc(8);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h7c, 32'h48);
    chk({31'h0, drvOut.sclOe}, 32'h1);
    apb(1'h1, CR, 8'h20);
    apb(1'h1, CR, 8'h00);
    cyc(8);
    chk({31'h0, drvOut.sclOe}, 32'h1);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h08, 32'h08);
    apb(1'h1, CR, 8'h08);
    cyc(8);
    chk({31'h0, drvOut.sclOe}, 32'h0);
  endtask
  // two received bits; data read clears ready, control read does not
  task automatic testReceive();
    busModel.sendBit(1'h0);
    cyc(8);
    apb(1'h0, DR, 8'h0);
    chk(rd, 32'h0);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h20, 32'h0);
    busModel.sendBit(1'h1);
    cyc(8);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'he0, 32'he0);
    chk({31'h0, drvOut.sclOe}, 32'h1);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h20, 32'h20);
    apb(1'h1, CR, 8'h20);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h60, 32'h0);
  endtask
  // send a zero, then a one that the far side overrides with a zero
  task automatic testTransmit();
    apb(1'h1, DR, 8'h00);
    cyc(4);
    chk({31'h0, drvOut.sdaOe}, 32'h1);
    busModel.sendBit(1'h1);
    cyc(8);
    apb(1'h0, DR, 8'h0);
    chk(rd, 32'h0);
    cyc(4);
    chk({31'h0, drvOut.sdaOe}, 32'h0);
    apb(1'h1, DR, 8'h80);
    busModel.sendBit(1'h0);
    cyc(8);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h30, 32'h30);
    apb(1'h1, CR, 8'h30);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h70, 32'h0);
  endtask
  // stop from the far side, then an ignoring slave woken by a start, then timeout
  task automatic testStopIgnore();
    busModel.sendStop();
    cyc(8);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h44, 32'h44);
    apb(1'h1, CR, 8'h24);
    apb(1'h1, CR, 8'h40);
    busModel.sendStart();
    cyc(8);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h48, 32'h0);
    busModel.sendBit(1'h1);
    cyc(8);
    chk({31'h0, drvOut.sclOe}, 32'h1);
    cyc(1100);
    chk({31'h0, drvOut.sclOe}, 32'h0);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h7c, 32'h0);
  endtask
  // ownership on a free bus, then request dropped and stop sent (software order)
  task automatic testOwner();
    apb(1'h1, CFG_ADDR, 8'h40);
    cyc(4);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h02, 32'h02);
    apb(1'h1, CFG_ADDR, 8'h00);
    apb(1'h1, CR, 8'h21);
    cyc(4);
    chk({31'h0, drvOut.sdaOe}, 32'h1);
    busModel.riseScl();
    cyc(120);
    chk({31'h0, drvOut.sdaOe}, 32'h0);
    apb(1'h0, CR, 8'h0);
    chk(rd & 32'h02, 32'h0);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    nrst    = 1'h0;
    psel    = 1'h0;
    penable = 1'h0;
    pwrite  = 1'h0;
    paddr   = 32'h0;
    pwdata  = 32'h0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'h1;
    @(posedge core_clk);
    testResetMap();
    testStart();
    testReceive();
    testTransmit();
    testStopIgnore();
    testOwner();
    complete_run();
  end
  // hang guards: overall cycle limit and a wire the far side could never raise
  initial begin
    repeat (40000) @(posedge core_clk);
    mismatches++;
    complete_run();
  end
  always @(posedge hung) begin
    mismatches++;
    complete_run();
  end
endmodule
`default_nettype wire

// file: i2cbit_bus_model.sv
// Purpose: the other device on the two-wire bus, acting as master or slave
// Assumes: both lines have pull-ups; the bench resolves the wire levels
// Notes:   scl half period 200 ns, scl moves only inside frames
`timescale 1ns/1ns
`default_nettype none
module i2cbit_bus_model (
  input  wire logic sclLine,
  input  wire logic sdaLine,
  output logic      sclLow,
  output logic      sdaLow,
  output logic      hung
);
  // ==========================================================
  // line drivers
  // both lines start released so the pull-ups hold them high
  initial begin
    sclLow = 1'h0;
    sdaLow = 1'h0;
    hung   = 1'h0;
  end
  // release scl and wait out any stretching, bounded so a stuck wire is flagged
  task automatic riseScl();
    int n;
    sclLow = 1'h0;
    n = 0;
    while (sclLine !== 1'h1 && n < 4000) begin
      #50;
      n++;
    end
    if (n >= 4000) hung = 1'h1;
    #200;
  endtask
  // start: sda falls while scl is high, then scl falls
  task automatic sendStart();
    sdaLow = 1'h0;
    #200;
    riseScl();
    sdaLow = 1'h1;
    #200;
    sclLow = 1'h1;
    #200;
  endtask
  // one bit: data set while scl is low, one high phase, scl pulled low again
  task automatic sendBit(input logic b);
    sdaLow = ~b;
    #200;
    riseScl();
    sclLow = 1'h1;
    #200;
  endtask
  // stop: sda low under scl low, scl rises, then sda rises
  task automatic sendStop();
    sdaLow = 1'h1;
    #200;
    riseScl();
    sdaLow = 1'h0;
    #200;
  endtask
endmodule
`default_nettype wire

// file: i2cbit_core.sv
// Purpose: single-bit two-wire bus interface with APB registers
// Assumes: SDA and SCL are open-drain, resolved outside
// Notes:   outputs are registered; pins pass two flops
`timescale 1ns/1ns
`default_nettype none
module i2cbit_core
  import i2cbit_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 nrst,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [31:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  input  wire i2cbit_pkg::i2cbit_pins_t pinsIn,
  output i2cbit_pkg::i2cbit_drv_t   drvOut
);
  // ==========================================================
  // pin synchronisers
  logic sclS;
  logic sdaS;
  i2cbit_sync uSyncScl (.core_clk(core_clk), .nrst(nrst), .asyncIn(pinsIn.sclIn),
                        .syncOut(sclS));
  i2cbit_sync uSyncSda (.core_clk(core_clk), .nrst(nrst), .asyncIn(pinsIn.sdaIn),
                        .syncOut(sdaS));

  // ==========================================================
  // state
  logic sclP_q, sdaP_q;
  logic rxBit_q, rdy_q, arl_q, str_q, stp_q, own_q, ownRq_q, ignore_q;
  logic txAct_q, txVal_q, sdaDrv_q, busy_q, stretch_q;
  i2cbit_txkind_t txKind_q;
  logic [TMO_W-1:0] tmo_q;
  logic [7:0] minCnt_q;
  logic ownRqSeen_q;

  // ==========================================================
  // edge and condition detection on synchronised pins
  wire sclRise  = sclS & ~sclP_q;
  wire sclFall  = ~sclS & sclP_q;
  wire startDet = sclS & sclP_q & sdaP_q & ~sdaS;
  wire stopDet  = sclS & sclP_q & ~sdaP_q & sdaS;
  wire timeout  = busy_q && (tmo_q == TMO_W'(TIMEOUT_CYC));
  wire anyFlag  = rdy_q | arl_q | str_q | stp_q;

  // ==========================================================
  // APB decode: zero-wait, writes and reads at the access edge
  wire acc     = psel & penable;
  wire wr      = acc & pwrite;
  wire rd      = acc & ~pwrite;
  wire hitCtrl = paddr[11:0] == CTRL_ADDR;
  wire hitData = paddr[11:0] == DATA_ADDR;
  wire hitCfg  = paddr[11:0] == CFG_ADDR;
  wire mapped  = hitCtrl | hitData | hitCfg;
  wire wCtrl   = wr & hitCtrl;
  wire wData   = wr & hitData;
  wire rData   = rd & hitData;
  wire wCfg    = wr & hitCfg;
  wire cmdCxa  = wCtrl & pwdata[BIT_RECEIVED_BIT];
  wire cmdIdle = wCtrl & pwdata[BIT_ATN];
  wire cmdCdr  = wCtrl & pwdata[BIT_RDY];
  wire cmdCarl = wCtrl & pwdata[BIT_ARL];
  wire cmdCstr = wCtrl & pwdata[BIT_STR];
  wire cmdCstp = wCtrl & pwdata[BIT_STP];
  wire cmdXstr = wCtrl & pwdata[BIT_OWN];
  wire cmdXstp = wCtrl & pwdata[BIT_SEND_STOP_CMD];
  wire ctrlAtn = anyFlag;
  wire [7:0] ctrlRd = {rxBit_q, ctrlAtn, rdy_q, arl_q, str_q, stp_q, own_q, 1'b0};
  wire [7:0] dataRd = {rxBit_q, 7'h00};
  wire [7:0] cfgRd  = {1'b0, ownRq_q, 6'h00};
  wire [7:0] rdMux  = hitCtrl ? ctrlRd : hitData ? dataRd : hitCfg ? cfgRd : 8'h00;

  // ==========================================================
  // arbitration loss cases
  wire driveOne  = txAct_q & (txKind_q == TX_BIT) & txVal_q;
  wire lossBit   = sclRise & txAct_q & (txKind_q != TX_STOP) & sdaDrv_q == 1'b0
                   & ~sdaS & (txKind_q == TX_BIT ? txVal_q : 1'b1);
  wire lossRst   = startDet & driveOne;
  wire lossPre   = own_q & txAct_q & (txKind_q == TX_RESTART) & sclFall
                   & sdaDrv_q == 1'b0 & minCnt_q != 8'h00;
  wire lossStop  = own_q & txAct_q & (txKind_q == TX_STOP) & sclRise & sdaS;
  wire arlSet    = txAct_q & (lossBit | lossRst | lossPre | lossStop);
  wire rdyClr    = cmdCdr | wData | rData;
  wire busFree   = ~busy_q | stopDet;

  // ==========================================================
  // sample pins history
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sclP_q <= 1'b1;
      sdaP_q <= 1'b1;
    end else begin
      sclP_q <= sclS;
      sdaP_q <= sdaS;
    end
  end

  // ==========================================================
  // received bit and ready flag; set wins over clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rxBit_q <= 1'b1;
      rdy_q   <= 1'b0;
    end else if (timeout) begin
      rdy_q   <= 1'b0;
    end else begin
      if (sclRise) rxBit_q <= sdaS;
      if (sclRise && !ignore_q) rdy_q <= 1'b1;
      else if (rdyClr) rdy_q <= 1'b0;
    end
  end

  // ==========================================================
  // event flags: a new event beats a write-one clear
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      arl_q <= 1'b0;
      str_q <= 1'b0;
      stp_q <= 1'b0;
    end else if (timeout) begin
      arl_q <= 1'b0;
      str_q <= 1'b0;
      stp_q <= 1'b0;
    end else begin
      if (arlSet) arl_q <= 1'b1;
      else if (cmdCarl) arl_q <= 1'b0;
      if (startDet && !ignore_q) str_q <= 1'b1;
      else if (cmdCstr) str_q <= 1'b0;
      if (stopDet && !ignore_q) stp_q <= 1'b1;
      else if (cmdCstp) stp_q <= 1'b0;
    end
  end

  // ==========================================================
  // ignore, frame busy, ownership request
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      ignore_q <= 1'b0;
      busy_q   <= 1'b0;
      ownRq_q  <= 1'b0;
    end else begin
      if (wCfg) ownRq_q <= pwdata[BIT_OWNRQ];
      if (timeout || stopDet) busy_q <= 1'b0;
      else if (startDet) busy_q <= 1'b1;
      if (timeout || startDet) ignore_q <= 1'b0;
      else if (cmdIdle && !own_q) ignore_q <= 1'b1;
    end
  end

  // ==========================================================
  // ownership; the final stop is armed once the request drops
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      own_q       <= 1'b0;
      ownRqSeen_q <= 1'b0;
    end else if (timeout) begin
      own_q       <= 1'b0;
      ownRqSeen_q <= 1'b0;
    end else begin
      ownRqSeen_q <= own_q & ~ownRq_q;
      if (arlSet) own_q <= 1'b0;
      else if (cmdXstp && ownRqSeen_q) own_q <= 1'b0;
      else if (ownRq_q && busFree && !own_q) own_q <= 1'b1;
    end
  end

  // ==========================================================
  // transmit state and pending bit
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      txAct_q  <= 1'b0;
      txVal_q  <= 1'b1;
      txKind_q <= TX_BIT;
    end else if (timeout || arlSet) begin
      txAct_q  <= 1'b0;
    end else if (wData) begin
      txAct_q  <= 1'b1;
      txVal_q  <= pwdata[BIT_RECEIVED_BIT];
      txKind_q <= TX_BIT;
    end else if (cmdXstr || cmdXstp) begin
      txAct_q  <= 1'b1;
      txVal_q  <= cmdXstr;
      txKind_q <= cmdXstr ? TX_RESTART : TX_STOP;
    end else if (rData || cmdCxa) begin
      txAct_q  <= 1'b0;
    end
  end

  // ==========================================================
  // minimum-time counter after SCL rises for restart/stop edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      minCnt_q <= 8'h00;
    end else if (sclRise) begin
      minCnt_q <= 8'(MIN_CYCLES);
    end else if (minCnt_q != 8'h00 && sclS) begin
      minCnt_q <= minCnt_q - 8'h01;
    end
  end

  // ==========================================================
  // SDA drive: released at once when idle, on timeout or on loss; otherwise the value changes
  // only while SCL is low, except the timed restart/stop edge that must happen with SCL high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sdaDrv_q <= 1'b0;
    end else if (!txAct_q || timeout || arlSet) begin
      sdaDrv_q <= 1'b0;
    end else if (!sclS) begin
      sdaDrv_q <= (txKind_q == TX_STOP) | ~txVal_q;
    end else if (minCnt_q == 8'h01) begin
      if (txKind_q == TX_RESTART) sdaDrv_q <= 1'b1;
      else if (txKind_q == TX_STOP) sdaDrv_q <= 1'b0;
    end
  end

  // ==========================================================
  // clock stretch: only the falling edge starts it, so a flag raised
  // with SCL high never glitches the clock; any flag keeps it
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stretch_q <= 1'b0;
    end else if (timeout || !anyFlag) begin
      stretch_q <= 1'b0;
    end else if (sclFall || (stretch_q && !sclS)) begin
      stretch_q <= 1'b1;
    end
  end

  // ==========================================================
  // frame timeout: cleared by SCL changes, idle outside frames
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tmo_q <= '0;
    end else if (!busy_q || sclRise || sclFall || timeout) begin
      tmo_q <= '0;
    end else begin
      tmo_q <= tmo_q + TMO_W'(1);
    end
  end

  // ==========================================================
  // APB answer, zero wait states
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      prdata  <= {24'h000000, rdMux};
      pslverr <= psel & ~penable & ~mapped;
    end
  end

  // ==========================================================
  // open-drain outputs, high enable pulls low
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      drvOut <= '0;
    end else begin
      drvOut.sdaOe <= sdaDrv_q;
      drvOut.sclOe <= stretch_q & ~timeout;
    end
  end

  // ==========================================================
  // checks
  property p_flag_after_rise;
    @(posedge core_clk) disable iff (!nrst)
      (sclRise && !ignore_q && !timeout) |=> rdy_q;
  endproperty
  a_flag_after_rise: assert property (p_flag_after_rise) else $error("ready not set");

  property p_capture;
    @(posedge core_clk) disable iff (!nrst)
      sclRise |=> (rxBit_q == $past(sdaS));
  endproperty
  a_capture: assert property (p_capture) else $error("bit not captured");

  property p_rdclr;
    @(posedge core_clk) disable iff (!nrst)
      (rData && !sclRise) |=> !rdy_q;
  endproperty
  a_rdclr: assert property (p_rdclr) else $error("data read left ready");

  property p_sda_tx;
    @(posedge core_clk) disable iff (!nrst)
      sdaDrv_q |-> $past(txAct_q);
  endproperty
  a_sda_tx: assert property (p_sda_tx) else $error("SDA driven while idle");

  property p_arl_tx;
    @(posedge core_clk) disable iff (!nrst)
      $rose(arl_q) |-> $past(txAct_q) && !txAct_q;
  endproperty
  a_arl_tx: assert property (p_arl_tx) else $error("loss outside transmit");

  property p_stretch;
    @(posedge core_clk) disable iff (!nrst)
      (sclFall && anyFlag && !timeout) |=> ##1 drvOut.sclOe;
  endproperty
  a_stretch: assert property (p_stretch) else $error("no stretch");

  property p_release;
    @(posedge core_clk) disable iff (!nrst)
      !anyFlag [*2] |=> !drvOut.sclOe;
  endproperty
  a_release: assert property (p_release) else $error("SCL held without flag");

  property p_clear_arb_lost_cmd;
    @(posedge core_clk) disable iff (!nrst)
      (cmdCarl && !arlSet) |=> !arl_q;
  endproperty
  a_clear_arb_lost_cmd: assert property (p_clear_arb_lost_cmd) else $error("loss flag not cleared");

  property p_tmo;
    @(posedge core_clk) disable iff (!nrst)
      timeout |=> !rdy_q && !own_q && tmo_q == '0;
  endproperty
  a_tmo: assert property (p_tmo) else $error("timeout no reset");

  c_start: cover property (@(posedge core_clk) disable iff (!nrst) $rose(str_q));
  c_stop: cover property (@(posedge core_clk) disable iff (!nrst) $rose(stp_q));
  c_arl: cover property (@(posedge core_clk) disable iff (!nrst) $rose(arl_q));
  c_own: cover property (@(posedge core_clk) disable iff (!nrst) $rose(own_q));
endmodule
`default_nettype wire

// file: i2cbit_pkg.sv
// Purpose: shared constants and types for the single-bit two-wire bus port
// Assumes: 32-bit APB, 20 MHz core clock
// Notes:   register offsets are word indexes; byte address is four times each
package i2cbit_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] CTRL_OFFSET  = 8'hd8;  // bus_control_reg
  localparam logic [7:0] DATA_OFFSET  = 8'hd9;  // bus_data_reg
  localparam logic [7:0] CFG_OFFSET   = 8'hdc;  // bus_config_reg, owner request
  // one aligned 32-bit word per register, so byte address = index * 4
  localparam logic [11:0] CTRL_ADDR   = {2'b00, CTRL_OFFSET, 2'b00};
  localparam logic [11:0] DATA_ADDR   = {2'b00, DATA_OFFSET, 2'b00};
  localparam logic [11:0] CFG_ADDR    = {2'b00, CFG_OFFSET, 2'b00};
  localparam logic [7:0] CTRL_RESET   = 8'h81;
  // bit positions
  localparam int BIT_RECEIVED_BIT  = 7;
  localparam int BIT_ATN   = 6;
  localparam int BIT_RDY   = 5;
  localparam int BIT_ARL   = 4;
  localparam int BIT_STR   = 3;
  localparam int BIT_STP   = 2;
  localparam int BIT_OWN   = 1;
  localparam int BIT_SEND_STOP_CMD  = 0;
  localparam int BIT_OWNRQ = 6;
  // ==========================================================
  // timing
  localparam int CLK_HZ       = 20000000;
  localparam int MIN_TIME_NS  = 4700;
  localparam int MIN_CYCLES   = (MIN_TIME_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int TIMEOUT_CYC  = 1020;
  localparam int TMO_W        = 10;
  // ==========================================================
  typedef struct packed {
    logic sclIn;
    logic sdaIn;
  } i2cbit_pins_t;
  typedef struct packed {
    logic sclOe;
    logic sdaOe;
  } i2cbit_drv_t;
  typedef enum logic [1:0] {TX_BIT, TX_RESTART, TX_STOP} i2cbit_txkind_t;
endpackage

// file: i2cbit_sync.sv
// Purpose: two-flop synchroniser for one pin
// Assumes: input is asynchronous to core_clk
// Notes:   first stage is read by the second stage only
`timescale 1ns/1ns
`default_nettype none
module i2cbit_sync (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic asyncIn,
  output logic      syncOut
);
  logic stage1_q;
  // ==========================================================
  // idle level of an open-drain wire is high
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      stage1_q <= 1'b1;
      syncOut  <= 1'b1;
    end else begin
      stage1_q <= asyncIn;
      syncOut  <= stage1_q;
    end
  end
endmodule
`default_nettype wire
